// >>> design/ledpu_seq.sv
// power-up sequencer: qualification, gate wait, led detect, classification
// How it works
// [R01] start needs enable high for the minimum first on-time and lockout cleared
// [R02] frequency-set pin held low blocks start of power-up unless a sync clock is seen
// [R03] a system check phase runs before any led sink is enabled
// [R04] after qualify, drive the disconnect gate, then check led pins
// [R05] detect begins only once the gate-level flag is seen
// [R06] after any pin passes 120 mV, time a fixed switching-cycle window
// [R07] below 70 mV short halts; near 150 mV unused; above 325 mV in use
// [R08] while any pin stays shorted, hold and rerun detect once released
// [R09] power-up only when the pin rises released or sync clock is seen
// [R10] enable low for 32750 switching cycles shuts down to low power
// [R11] all comparator flags pass a two-flop synchroniser first
`timescale 1ns/1ps
`include "ledpu_cfg.svh"
module ledpu_seq
  import ledpu_pkg::*;
#(
  parameter int CHANNELS = `LEDPU_CHANNELS,
  parameter int DETECT_CYCLES = `LEDPU_DETECT_SW_CYC,
  parameter int ENABLE_LOW_CYCLES = `LEDPU_ENABLE_LOW_SW_CYC,
  parameter int MIN_HIGH_CYCLES = `LEDPU_MIN_EN_HIGH_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // switching-clock enable from the oscillator divider
  input wire logic sw_tick,
  // host enable and comparator flags
  input wire logic enable_pin,
  input wire logic supply_lockout,
  input wire logic freq_set_sync_pin,
  input wire logic sync_clock_seen,
  input wire logic gate_level_ok,
  input wire logic [CHANNELS-1:0] led_above_120mv,
  input wire logic [CHANNELS-1:0] led_below_70mv,
  input wire logic [CHANNELS-1:0] led_above_325mv,
  // outputs
  output logic disconnect_gate_drive,
  output logic detect_active,
  output logic [CHANNELS-1:0] channel_enable,
  output logic [CHANNELS-1:0] channel_unused,
  output logic short_fault,
  output logic powered_up,
  output logic low_power
);
  // refuse settings the 16-bit counters and flag packing cannot serve
  if (CHANNELS < 1 || CHANNELS > 32) begin : g_bad_channels
    $error("CHANNELS out of range");
  end
  if (DETECT_CYCLES < `LEDPU_DETECT_MIN_SW_CYC ||
      DETECT_CYCLES > `LEDPU_DETECT_MAX_SW_CYC) begin : g_bad_detect
    $error("DETECT_CYCLES out of range");
  end
  if (ENABLE_LOW_CYCLES < 2 || ENABLE_LOW_CYCLES > 65536) begin : g_bad_low
    $error("ENABLE_LOW_CYCLES out of range");
  end
  if (MIN_HIGH_CYCLES < 1 || MIN_HIGH_CYCLES > 65536) begin : g_bad_high
    $error("MIN_HIGH_CYCLES out of range");
  end

  localparam int NF = 4 + 3 * CHANNELS;
  logic [NF-1:0] raw_flags;
  logic [NF-1:0] flags;
  assign raw_flags = {led_above_325mv, led_below_70mv, led_above_120mv,
                      gate_level_ok, sync_clock_seen, freq_set_sync_pin, supply_lockout};

  ledpu_sync #(.WIDTH(NF)) ledpu_sync_i ( // R11
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(raw_flags),
    .sync_out(flags)
  );

  logic lockout_s, fset_s, syncclk_s, gate_s;
  logic [CHANNELS-1:0] p120_s, p70_s, p325_s;
  logic en_meta, en_s;
  assign lockout_s = flags[0];
  assign fset_s = flags[1];
  assign syncclk_s = flags[2];
  assign gate_s = flags[3];
  assign p120_s = flags[4 +: CHANNELS];
  assign p70_s = flags[4+CHANNELS +: CHANNELS];
  assign p325_s = flags[4+2*CHANNELS +: CHANNELS];

  function automatic logic any_set(input logic [CHANNELS-1:0] v);
    return |v;
  endfunction

  ledpu_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [15:0] low_cnt, next_low_cnt;
  logic next_gate, next_det, next_short, next_up, next_lp;
  logic [CHANNELS-1:0] next_en, next_unused;
  logic next_en_meta;
  logic pin_ready;

  // released pin or detected sync clock lets power-up proceed
  assign pin_ready = fset_s || syncclk_s; // R02 R09

  always_comb begin
    next_en_meta = enable_pin;
    next_state = state;
    next_cnt = cnt;
    next_low_cnt = low_cnt;
    next_gate = disconnect_gate_drive;
    next_det = 1'b0;
    next_short = short_fault;
    next_up = powered_up;
    next_lp = low_power;
    next_en = channel_enable;
    next_unused = channel_unused;
    // long enable-low shuts the device down
    if (en_s) begin
      next_low_cnt = 16'h0000;
    end else if (sw_tick && state != LEDPU_OFF) begin
      next_low_cnt = low_cnt + 16'h0001;
    end
    case (state)
      LEDPU_OFF: begin
        next_gate = 1'b0;
        next_en = '0;
        next_up = 1'b0;
        next_short = 1'b0;
        next_cnt = 16'h0000;
        if (en_s && !lockout_s && pin_ready) begin // R01 R02
          next_state = LEDPU_QUAL;
        end
      end
      LEDPU_QUAL: begin
        if (!en_s || lockout_s || !pin_ready) begin
          next_state = LEDPU_OFF;
        end else if (cnt >= 16'(MIN_HIGH_CYCLES - 1)) begin // R01
          next_state = LEDPU_GATE;
          next_gate = 1'b1; // R04
          next_lp = 1'b0;
          next_cnt = 16'h0000;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
      end
      LEDPU_GATE: begin
        if (gate_s) begin // R05
          next_state = LEDPU_ARM;
        end
      end
      LEDPU_ARM: begin
        next_det = 1'b1; // R03
        // a grounded pin never rises, so waiting for all pins would hide a short
        if (any_set(p120_s)) begin // R06
          next_state = LEDPU_DETECT;
          next_cnt = 16'h0000;
        end
      end
      LEDPU_DETECT: begin
        next_det = 1'b1;
        if (sw_tick) begin
          if (cnt >= 16'(DETECT_CYCLES - 1)) begin // R06
            next_cnt = 16'h0000;
            if (any_set(p70_s)) begin // R07
              next_state = LEDPU_SHORT;
              next_short = 1'b1;
            end else begin
              next_state = LEDPU_RUN;
              next_en = p325_s; // R07
              next_unused = ~p325_s; // R07
              next_up = 1'b1; // R03
            end
          end else begin
            next_cnt = cnt + 16'h0001;
          end
        end
      end
      LEDPU_SHORT: begin
        next_det = 1'b1;
        if (!any_set(p70_s)) begin // R08
          next_short = 1'b0;
          next_state = LEDPU_ARM;
        end
      end
      LEDPU_RUN: begin
        next_up = 1'b1;
      end
      default: begin
        next_state = LEDPU_OFF;
      end
    endcase
    if (state != LEDPU_OFF && sw_tick && !en_s &&
        low_cnt >= 16'(ENABLE_LOW_CYCLES - 1)) begin // R10
      next_state = LEDPU_OFF;
      next_lp = 1'b1;
      next_gate = 1'b0;
      next_en = '0;
      next_up = 1'b0;
      next_det = 1'b0;
      next_low_cnt = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      en_meta <= 1'b0;
      en_s <= 1'b0;
      state <= LEDPU_OFF;
      cnt <= 16'h0000;
      low_cnt <= 16'h0000;
      disconnect_gate_drive <= 1'b0;
      detect_active <= 1'b0;
      short_fault <= 1'b0;
      powered_up <= 1'b0;
      low_power <= 1'b1;
      channel_enable <= '0;
      channel_unused <= '0;
    end else begin
      en_meta <= next_en_meta;
      en_s <= en_meta;
      state <= next_state;
      cnt <= next_cnt;
      low_cnt <= next_low_cnt;
      disconnect_gate_drive <= next_gate;
      detect_active <= next_det;
      short_fault <= next_short;
      powered_up <= next_up;
      low_power <= next_lp;
      channel_enable <= next_en;
      channel_unused <= next_unused;
    end
  end

  chk_gate_before_detect: assert property (@(posedge ref_clk) disable iff (!resetn) // R05
    $rose(detect_active) |-> disconnect_gate_drive)
    else $error("detect started without gate drive");
  chk_short_no_enable: assert property (@(posedge ref_clk) disable iff (!resetn) // R08
    short_fault |-> channel_enable == '0)
    else $error("channel enabled while shorted");
  chk_pin_low_block: assert property (@(posedge ref_clk) disable iff (!resetn) // R02
    (state == LEDPU_OFF && !pin_ready) |=> state == LEDPU_OFF)
    else $error("power-up began with pin held low");
  chk_lockout_block: assert property (@(posedge ref_clk) disable iff (!resetn) // R01
    (state == LEDPU_OFF && lockout_s) |=> state == LEDPU_OFF)
    else $error("power-up began under lockout");
  chk_enable_classify: assert property (@(posedge ref_clk) disable iff (!resetn) // R07
    $rose(powered_up) |-> channel_enable == ~channel_unused)
    else $error("channel classification inconsistent");
  chk_up_no_short: assert property (@(posedge ref_clk) disable iff (!resetn) // R07
    $rose(powered_up) |-> $past(p70_s) == '0)
    else $error("powered up with a shorted pin");
  chk_gate_follows: assert property (@(posedge ref_clk) disable iff (!resetn) // R04
    (state == LEDPU_GATE) |-> disconnect_gate_drive && !detect_active)
    else $error("gate drive not raised before pin check");
  chk_lowpower_off: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
    $rose(low_power) |-> !disconnect_gate_drive && !powered_up)
    else $error("low power entered with outputs active");
  chk_detect_count: assert property (@(posedge ref_clk) disable iff (!resetn) // R06
    (state == LEDPU_DETECT) |-> cnt < 16'(DETECT_CYCLES))
    else $error("detect window overran");
  chk_enable_only_up: assert property (@(posedge ref_clk) disable iff (!resetn) // R03
    (channel_enable != '0) |-> powered_up)
    else $error("sink enabled before check done");
endmodule

// >>> design/ledpu_sync.sv
// two-flop synchroniser for a bundle of comparator flags
`timescale 1ns/1ps
module ledpu_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // flags
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH out of range");
  end

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule

// >>> include/ledpu_cfg.svh
// timing counts and channel figures for the power-up sequencer
`ifndef LEDPU_CFG_SVH
`define LEDPU_CFG_SVH
`define LEDPU_CLK_MHZ 100
`define LEDPU_CHANNELS 8
`define LEDPU_MIN_EN_HIGH_NS 2000
`define LEDPU_MIN_EN_HIGH_CYC ((`LEDPU_MIN_EN_HIGH_NS * `LEDPU_CLK_MHZ + 999) / 1000)
`define LEDPU_DETECT_SW_CYC 3500
`define LEDPU_DETECT_MIN_SW_CYC 3000
`define LEDPU_DETECT_MAX_SW_CYC 4000
`define LEDPU_ENABLE_LOW_SW_CYC 32750
`endif

// >>> include/ledpu_pkg.sv
// types for the power-up sequencer
package ledpu_pkg;
  typedef enum logic [2:0] {
    LEDPU_OFF,
    LEDPU_QUAL,
    LEDPU_GATE,
    LEDPU_ARM,
    LEDPU_DETECT,
    LEDPU_SHORT,
    LEDPU_RUN
  } ledpu_state_t;
endpackage

// >>> test/ledpu_seq_bench.sv
// self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module ledpu_seq_bench;
  logic ref_clk, resetn, enable_pin, supply_lockout, freq_set_sync_pin;
  logic sw_tick = 1'b0;
  logic sync_clock_seen, gate_level_ok, disconnect_gate_drive, detect_active;
  logic short_fault, powered_up, low_power;
  logic [7:0] a120, b70, a325, channel_enable, channel_unused;
  logic [7:0][9:0] pin_mv;
  int n_mismatch = 0;
  int check_count = 0;
  int tk = 0;
  ledpu_strings ledpu_strings_i (.pin_mv(pin_mv), .above_120mv(a120), .below_70mv(b70),
    .above_325mv(a325));
  ledpu_seq #(.ENABLE_LOW_CYCLES(20), .MIN_HIGH_CYCLES(4)) ledpu_seq_i (.ref_clk(ref_clk),
    .resetn(resetn), .sw_tick(sw_tick), .enable_pin(enable_pin),
    .supply_lockout(supply_lockout), .freq_set_sync_pin(freq_set_sync_pin),
    .sync_clock_seen(sync_clock_seen), .gate_level_ok(gate_level_ok),
    .led_above_120mv(a120), .led_below_70mv(b70), .led_above_325mv(a325),
    .disconnect_gate_drive(disconnect_gate_drive), .detect_active(detect_active),
    .channel_enable(channel_enable), .channel_unused(channel_unused),
    .short_fault(short_fault), .powered_up(powered_up), .low_power(low_power));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // switching clock: one tick every fourth cycle
  always @(negedge ref_clk) begin
    tk <= (tk + 1) % 4;
    sw_tick <= (tk == 3);
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rst();
    resetn = 1'b0;
    enable_pin = 1'b0;
    supply_lockout = 1'b1;
    freq_set_sync_pin = 1'b0;
    sync_clock_seen = 1'b0;
    gate_level_ok = 1'b0;
    pin_mv = '0;
    cyc(10);
    resetn = 1'b1;
    chk("low_power", 8'h01, {7'h00, low_power});
  endtask
  task automatic t_qualify();
    rst();
    supply_lockout = 1'b0;
    freq_set_sync_pin = 1'b1;
    enable_pin = 1'b1;
    cyc(2);
    enable_pin = 1'b0;
    cyc(20);
    chk("gate_short_en", 8'h00, {7'h00, disconnect_gate_drive});
    enable_pin = 1'b1;
    freq_set_sync_pin = 1'b0;
    cyc(40);
    chk("gate_pin_low", 8'h00, {7'h00, disconnect_gate_drive});
    freq_set_sync_pin = 1'b1;
    supply_lockout = 1'b1;
    cyc(40);
    chk("gate_lockout", 8'h00, {7'h00, disconnect_gate_drive});
    supply_lockout = 1'b0;
    freq_set_sync_pin = 1'b0;
    sync_clock_seen = 1'b1;
    cyc(15);
    chk("gate_sync", 8'h01, {7'h00, disconnect_gate_drive});
  endtask
  task automatic t_detect(input logic [7:0] used, input logic shorted);
    int n;
    int w;
    rst();
    supply_lockout = 1'b0;
    freq_set_sync_pin = 1'b1;
    enable_pin = 1'b1;
    for (int i = 0; i < 8; i++) pin_mv[i] = used[i] ? 10'h1F4 : 10'h096;
    cyc(30);
    chk("gate_on", 8'h01, {7'h00, disconnect_gate_drive});
    chk("lp_clear", 8'h00, {7'h00, low_power});
    chk("pre_gate", 8'h00, {7'h00, detect_active});
    gate_level_ok = 1'b1;
    if (shorted) begin
      cyc(20);
      pin_mv[0] = 10'h000;
      cyc(15000);
      chk("short", 8'h01, {7'h00, short_fault});
      chk("halted", 8'h00, {7'h00, powered_up});
      chk("sinks_off", 8'h00, channel_enable);
      pin_mv[0] = 10'h1F4;
    end
    n = 0;
    w = 0;
    // sample away from the launching edge; w bounds a window that never ends
    while (powered_up !== 1'b1 && w < 20000) begin
      @(negedge ref_clk);
      w++;
      if (sw_tick && detect_active === 1'b1) n++;
    end
    @(negedge ref_clk);
    chk("window_min", 8'h01, {7'h00, n >= 3000});
    chk("window_max", 8'h01, {7'h00, n <= 4000});
    chk("short_clear", 8'h00, {7'h00, short_fault});
    chk("enabled", used, channel_enable);
    chk("unused", ~used, channel_unused);
  endtask
  task automatic t_shutdown();
    t_detect(8'hFF, 1'b0);
    enable_pin = 1'b0;
    cyc(60);
    chk("lp_early", 8'h00, {7'h00, low_power});
    cyc(60);
    chk("lp_late", 8'h01, {7'h00, low_power});
    chk("gate_off", 8'h00, {7'h00, disconnect_gate_drive});
    chk("up_off", 8'h00, {7'h00, powered_up});
    chk("sinks_down", 8'h00, channel_enable);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    t_qualify();
    t_detect(8'h5A, 1'b0);
    t_detect(8'h7F, 1'b1);
    t_shutdown();
    results();
  end
  // cut a hang short well past the expected run length
  initial begin
    #800000;
    n_mismatch++;
    results();
  end
endmodule

// >>> test/ledpu_strings.sv
// led string model: pin voltage in mV to the sink comparator flags
`timescale 1ns/1ps
module ledpu_strings (
  // pin voltages
  input wire logic [7:0][9:0] pin_mv,
  // comparator flags
  output logic [7:0] above_120mv,
  output logic [7:0] below_70mv,
  output logic [7:0] above_325mv
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      above_120mv[i] = pin_mv[i] > 10'h078;
      below_70mv[i] = pin_mv[i] < 10'h046;
      above_325mv[i] = pin_mv[i] > 10'h145;
    end
  end
endmodule
